// [shared/pss_defs.vh]
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// ----------------------------------------
// Bus addressing
// ----------------------------------------
// Chip address on the serial bus, value is arbitrary
`define PSS_DEV_ADDR        7'h2c
// Control register subaddress and register file size
`define PSS_CTRL_SUB        8'h1a
`define PSS_REG_COUNT       32
`define PSS_REG_AW          5

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define PSS_CTRL_SOFT_POS   0
`define PSS_CTRL_STBY_POS   1
`define PSS_CTRL_RESET      8'h00

// ----------------------------------------
// Status byte returned on a bus read
// ----------------------------------------
`define PSS_STAT_SOFT_POS   0
`define PSS_STAT_PROT_POS   1
`define PSS_STAT_DIP_POS    2
`define PSS_STAT_GUARD_POS  3
`define PSS_STAT_LOAD_POS   4
`define PSS_STAT_DONE_POS   5

// ----------------------------------------
// Soft start timing
// ----------------------------------------
`define PSS_CLK_MHZ         100
`define PSS_STEP_TIME_US    10
`define PSS_STEP_CYCLES     (`PSS_STEP_TIME_US * `PSS_CLK_MHZ)
`define PSS_STEP_W          10
`define PSS_STAGE_W         3
`define PSS_STAGE_LAST      3'h6

`endif

// [design/pss_soft_seq.v]
`timescale 1ns/10ps
`include "pss_defs.vh"

// Steps the outputs on one stage at a time after a start request;
// any loss of the request drops every stage at once.
module pss_soft_seq
(
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      reset_n,
    // Request and progress
    input  wire                      runRequest,
    output reg  [`PSS_STAGE_W-1:0]   stage,
    output wire                      seqDone
);

    reg [`PSS_STEP_W-1:0] stepCount;

    // Last count of a step, cut to the counter width on purpose
    localparam [31:0] STEP_LAST = `PSS_STEP_CYCLES - 1;

    assign seqDone = (stage == `PSS_STAGE_LAST);

    // ----------------------------------------
    // Stage counter
    // ----------------------------------------
    // R16 ordered enabling steps
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage     <= 3'h0;
            stepCount <= 10'h000;
        end
        else if (!runRequest)
        begin
            // Shutdown is immediate: protection never waits on a step
            stage     <= 3'h0;
            stepCount <= 10'h000;
        end
        else if (!seqDone)
        begin
            if (stepCount == STEP_LAST[`PSS_STEP_W-1:0])
            begin
                stepCount <= 10'h000;
                stage     <= stage + 3'h1;
            end
            else
            begin
                stepCount <= stepCount + 10'h001;
            end
        end
    end

endmodule // pss_soft_seq

// [design/pss_protect_top.v]
`timescale 1ns/10ps
`include "pss_defs.vh"

// What the document asks of this block and its bus master
// R1 - Outputs off until supply and first write
// R2 - Below threshold: standby, no acknowledge
// R3 - Low supply clears the soft start bit
// R4 - Above threshold all registers are loadable (block takes only 1AH data until soft start is set with standby clear)
// R5 - Setting soft start releases the outputs
// R6 - Dip during running: protection, unlock floats
// R7 - Pulled phase-loop pin holds protection
// R8 - Dip recovery: reload, then I2C or supply
// R9 - Low supply recovery: reload plus I2C start
// R10 - Protection floats the horizontal drive
// R11 - Protection floats the B+ drive
// R12 - Protection floats the unlock flag
// R13 - Protection forces continuous blanking
// R14 - Protection floats both vertical outputs
// R15 - Protection discharges the phase-loop capacitor
// R16 - Soft start enables outputs in order
// R17 - Standby acknowledges data only at 1AH
// R18 - Control register holds standby, soft start
// R19 - Standby: ack address, subaddress, not data
// R20 - Master probes standby via 0XH writes
// R21 - Master's first write goes to 1AH
// R22 - Analog detector inputs are synchronised first
module pss_protect_top
(
    // Clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // Analog detector indications
    input  wire supplyAbove83,
    input  wire supplyAbove81,
    input  wire overvoltageGuardInput,
    input  wire phaseLoopFilterPin,
    input  wire pllUnlock,
    // Serial bus pins
    input  wire scl,
    input  wire sdaIn,
    output wire sdaOut,
    output reg  sdaOe,
    // Gated outputs, enable high means driven
    output reg  horizontalDriveOutEn,
    output reg  bplusDriveOutEn,
    output reg  verticalOutAEn,
    output reg  verticalOutBEn,
    output wire syncUnlockFlagOut,
    output reg  syncUnlockFlagOe,
    output reg  clampBlankForce,
    output reg  phaseLoopDischarge
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam NSYNC = 7;
    wire [NSYNC-1:0] rawIn = {sdaIn, scl, pllUnlock, phaseLoopFilterPin,
                              overvoltageGuardInput, supplyAbove81, supplyAbove83};
    reg  [NSYNC-1:0] syncA;
    reg  [NSYNC-1:0] syncB;

    // R22 two-stage synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end
                else
                begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    wire ok83     = syncB[0];
    wire ok81     = syncB[1];
    wire guardHit = syncB[2];
    wire pinHigh  = syncB[3];
    wire unlockIn = syncB[4];
    wire sclS     = syncB[5];
    wire sdaS     = syncB[6];

    // ----------------------------------------
    // Bus edge and condition detection
    // ----------------------------------------
    reg  sclD;
    reg  sdaD;
    wire sclRise = sclS & ~sclD;
    wire sclFall = ~sclS & sclD;
    wire startCond = sclS & sclD & sdaD & ~sdaS;
    wire stopCond  = sclS & sclD & ~sdaD & sdaS;

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclD <= 1'b1;
            sdaD <= 1'b1;
        end
        else
        begin
            sclD <= sclS;
            sdaD <= sdaS;
        end
    end

    // ----------------------------------------
    // Control and protection state
    // ----------------------------------------
    reg  softStartBit;
    reg  standbyBit;
    reg  regsLoaded;
    reg  dipLatched;
    reg  guardLatched;
    reg  autoRestart;
    reg  ok81D;
    reg  runSeen;
    wire [`PSS_STAGE_W-1:0] stage;
    localparam [7:0] CTRL_RST = `PSS_CTRL_RESET;
    wire seqDone;

    // Normal registers accept data only in this state
    wire deviceActive = softStartBit & ~standbyBit & ok83;
    wire running      = deviceActive & seqDone;
    wire dipEvent     = ok81D & ~ok81 & runSeen;
    // R7 pulled loop pin forces protection
    wire protActive   = ~ok83 | dipLatched | guardLatched | ~pinHigh;
    wire runRequest   = deviceActive & regsLoaded & ~protActive;

    // Register file written from the bus
    reg  [7:0] regFile [0:`PSS_REG_COUNT-1];
    wire       dataWrite;
    wire       ctrlWrite;
    reg  [7:0] subAddr;
    reg  [7:0] shiftReg;

    // The upper threshold always falls first, so a run is remembered
    // through the sag until the lower one falls or supply comes back
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ok81D   <= 1'b0;
            runSeen <= 1'b0;
        end
        else
        begin
            ok81D   <= ok81;
            runSeen <= (running | (runSeen & ~ok83)) & ~dipEvent;
        end
    end

    // R3 low supply clears soft start
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            softStartBit <= CTRL_RST[`PSS_CTRL_SOFT_POS];
            standbyBit   <= CTRL_RST[`PSS_CTRL_STBY_POS];
        end
        else if (!ok83 || dipEvent || guardHit)
        begin
            softStartBit <= 1'b0;
        end
        // R18 control register fields
        else if (ctrlWrite)
        begin
            softStartBit <= shiftReg[`PSS_CTRL_SOFT_POS];
            standbyBit   <= shiftReg[`PSS_CTRL_STBY_POS];
        end
        // R8 restart on returning supply
        else if (autoRestart)
        begin
            softStartBit <= 1'b1;
        end
    end

    // R1 first write arms outputs
    // R9 low supply, dip or guard trip demands reload
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            regsLoaded <= 1'b0;
        else if (!ok83 || dipEvent || guardHit)
            regsLoaded <= 1'b0;
        else if (dataWrite)
            regsLoaded <= 1'b1;
    end

    // R6 dip latch, cleared by soft start
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dipLatched   <= 1'b0;
            guardLatched <= 1'b0;
            autoRestart  <= 1'b0;
        end
        else
        begin
            // Hardware set wins over a clearing write
            if (dipEvent)
                dipLatched <= 1'b1;
            // Either soft start path ends the dip protection
            else if ((ctrlWrite && shiftReg[`PSS_CTRL_SOFT_POS]) || (autoRestart && ok83))
                dipLatched <= 1'b0;
            if (guardHit)
                guardLatched <= 1'b1;
            else if (ctrlWrite && shiftReg[`PSS_CTRL_SOFT_POS])
                guardLatched <= 1'b0;
            // Supply return restarts only after a dip
            if (dipEvent)
                autoRestart <= 1'b1;
            else if (ctrlWrite || guardHit || (autoRestart && ok83))
                autoRestart <= 1'b0;
        end
    end

    pss_soft_seq u_seq
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .runRequest (runRequest),
        .stage      (stage),
        .seqDone    (seqDone)
    );

    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    // R5 outputs follow the started sequence
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phaseLoopDischarge   <= 1'b1;
            verticalOutAEn       <= 1'b0;
            verticalOutBEn       <= 1'b0;
            horizontalDriveOutEn <= 1'b0;
            bplusDriveOutEn      <= 1'b0;
            syncUnlockFlagOe     <= 1'b0;
            clampBlankForce      <= 1'b1;
        end
        else
        begin
            // R15 discharge the filter capacitor
            phaseLoopDischarge   <= (stage < 3'h1);
            // R14 vertical outputs float
            verticalOutAEn       <= (stage >= 3'h2);
            verticalOutBEn       <= (stage >= 3'h2);
            // R10 horizontal drive floats
            horizontalDriveOutEn <= (stage >= 3'h3);
            // R11 B+ drive floats
            bplusDriveOutEn      <= (stage >= 3'h4);
            // R12 unlock flag released high
            syncUnlockFlagOe     <= (stage >= 3'h5) & ~unlockIn;
            // R13 continuous blanking level
            clampBlankForce      <= (stage < `PSS_STAGE_LAST);
        end
    end

    // Open-drain flag only ever pulls low
    assign syncUnlockFlagOut = 1'b0;
    assign sdaOut            = 1'b0;

    // ----------------------------------------
    // Serial bus slave
    // ----------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_SUB  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_RD   = 3'h4;
    localparam ST_RACK = 3'h5;

    reg  [2:0] state;
    reg  [3:0] bitCnt;
    reg        inAck;
    reg        ackGiven;
    reg        storeData;
    reg  [7:0] readByte;
    wire [7:0] statusByte;

    assign statusByte = {2'h0, seqDone, regsLoaded, guardLatched, dipLatched,
                         protActive, softStartBit};
    assign ctrlWrite  = storeData & (subAddr == `PSS_CTRL_SUB);
    assign dataWrite  = storeData;

    // R2 no acknowledge at low supply
    // R17 standby acknowledges control data only
    // R19 address and subaddress acknowledged
    wire ackNow = (state == ST_ADDR) ? (shiftReg[7:1] == `PSS_DEV_ADDR) & ok83 :
                  (state == ST_SUB)  ? ok83 :
                  (state == ST_DATA) ? ok83 & (deviceActive | subAddr == `PSS_CTRL_SUB) :
                  1'b0;

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= ST_IDLE;
            bitCnt    <= 4'h0;
            inAck     <= 1'b0;
            ackGiven  <= 1'b0;
            sdaOe     <= 1'b0;
            storeData <= 1'b0;
            shiftReg  <= 8'h00;
            subAddr   <= 8'h00;
            readByte  <= 8'h00;
        end
        else
        begin
            storeData <= 1'b0;
            if (startCond)
            begin
                state  <= ST_ADDR;
                bitCnt <= 4'h0;
                inAck  <= 1'b0;
                sdaOe  <= 1'b0;
            end
            else if (stopCond)
            begin
                state <= ST_IDLE;
                inAck <= 1'b0;
                sdaOe <= 1'b0;
            end
            else if (sclRise && state != ST_IDLE)
            begin
                if (state == ST_RACK)
                    state <= sdaS ? ST_IDLE : ST_RD;
                else if (!inAck && bitCnt < 4'h8)
                begin
                    shiftReg <= {shiftReg[6:0], sdaS};
                    bitCnt   <= bitCnt + 4'h1;
                end
            end
            else if (sclFall && state != ST_IDLE)
            begin
                case (state)
                    ST_ADDR, ST_SUB, ST_DATA:
                    begin
                        if (inAck)
                        begin
                            // End of acknowledge slot
                            inAck  <= 1'b0;
                            sdaOe  <= 1'b0;
                            bitCnt <= 4'h0;
                            if (!ackGiven)
                                state <= ST_IDLE;
                            else if (state == ST_ADDR && shiftReg[0])
                            begin
                                state    <= ST_RD;
                                readByte <= statusByte;
                                sdaOe    <= ~statusByte[7];
                                bitCnt   <= 4'h1;
                            end
                            else if (state == ST_ADDR)
                                state <= ST_SUB;
                            else
                                state <= ST_DATA;
                        end
                        else if (bitCnt == 4'h8)
                        begin
                            inAck    <= 1'b1;
                            ackGiven <= ackNow;
                            sdaOe    <= ackNow;
                            if (state == ST_SUB)
                                subAddr <= shiftReg;
                            // R4 data stored when acknowledged
                            if (state == ST_DATA && ackNow)
                                storeData <= 1'b1;
                        end
                    end
                    ST_RD:
                    begin
                        if (bitCnt == 4'h8)
                        begin
                            sdaOe <= 1'b0;
                            state <= ST_RACK;
                        end
                        else
                        begin
                            sdaOe  <= ~readByte[3'h7 - bitCnt[2:0]];
                            bitCnt <= bitCnt + 4'h1;
                        end
                    end
                    ST_RACK:
                    begin
                        sdaOe    <= ~readByte[7];
                        bitCnt   <= 4'h1;
                        readByte <= statusByte;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register file store, control register mirrored too
    always @(posedge sys_clk)
    begin
        if (storeData)
            regFile[subAddr[`PSS_REG_AW-1:0]] <= shiftReg;
    end

endmodule // pss_protect_top

// [verification/pss_protect_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Pin-level protection checker
// ----------------------------------------
module pss_protect_properties
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Detector inputs
    input wire logic supplyAbove83,
    input wire logic phaseLoopFilterPin,
    // Outputs under watch
    input wire logic sdaOe,
    input wire logic horizontalDriveOutEn,
    input wire logic bplusDriveOutEn,
    input wire logic verticalOutAEn,
    input wire logic verticalOutBEn,
    input wire logic syncUnlockFlagOe,
    input wire logic clampBlankForce,
    input wire logic phaseLoopDischarge
);
    // Six cycles cover the input sync, the stage drop and the output register
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_low_supply_off: assert property (!supplyAbove83 [*6] |-> !horizontalDriveOutEn)
        else $error("horizontal drive on under low supply");
    a_low_no_ack: assert property (!supplyAbove83 [*8] |-> !sdaOe)
        else $error("bus answered under low supply");
    a_pin_hdrive: assert property (!phaseLoopFilterPin [*6] |-> !horizontalDriveOutEn)
        else $error("horizontal drive on in protection");
    a_pin_bplus: assert property (!phaseLoopFilterPin [*6] |-> !bplusDriveOutEn)
        else $error("B+ drive on in protection");
    a_pin_unlock: assert property (!phaseLoopFilterPin [*6] |-> !syncUnlockFlagOe)
        else $error("unlock flag pulled in protection");
    a_pin_blank: assert property (!phaseLoopFilterPin [*6] |-> clampBlankForce)
        else $error("blanking missing in protection");
    a_pin_vertical: assert property (!phaseLoopFilterPin [*6] |-> !(verticalOutAEn || verticalOutBEn))
        else $error("vertical output on in protection");
    a_pin_discharge: assert property (!phaseLoopFilterPin [*6] |-> phaseLoopDischarge)
        else $error("loop capacitor not discharged");
    a_order_vertical: assert property ($rose(verticalOutAEn) |-> !phaseLoopDischarge && !horizontalDriveOutEn)
        else $error("vertical stage out of order");
    a_order_bplus: assert property ($rose(bplusDriveOutEn) |-> $past(horizontalDriveOutEn, 200))
        else $error("B+ drive before horizontal drive");
    a_blank_last: assert property ($fell(clampBlankForce) |-> bplusDriveOutEn && verticalOutBEn)
        else $error("blanking lifted before drives");
endmodule // pss_protect_properties

bind pss_protect_top pss_protect_properties u_props
(
    .sys_clk, .reset_n, .supplyAbove83, .phaseLoopFilterPin, .sdaOe, .horizontalDriveOutEn,
    .bplusDriveOutEn, .verticalOutAEn, .verticalOutBEn, .syncUnlockFlagOe, .clampBlankForce,
    .phaseLoopDischarge
);

// [verification/pss_i2c_master.sv]
`timescale 1ns/10ps
`include "pss_defs.vh"
// ----------------------------------------
// Serial bus master stand-in
// ----------------------------------------
module pss_i2c_master
(
    // Clock
    input  wire logic sys_clk,
    // Bus pins
    input  wire logic sdaOe,
    output logic      scl,
    output wire logic sdaLine
);
    logic sdaLow;
    int   quarter;
    // Pull-up wins unless either side pulls the line low
    assign sdaLine = !(sdaLow || sdaOe);
    // Both lines idle high between frames
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
        quarter = 10;
    end
    // Changes land just after a clock edge; quarter sets prompt or slow
    task tick;
        repeat (quarter) @(posedge sys_clk);
        #1;
    endtask
    // One clock pulse, returning the line level seen while high
    task pulse(output logic lvl);
        tick;
        scl = 1'b1;
        tick;
        lvl = sdaLine;
        scl = 1'b0;
        tick;
    endtask
    // Most significant bit first, acknowledge read in the ninth pulse
    task send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sdaLow = !b[i];
            pulse(ack);
        end
        sdaLow = 1'b0;
        pulse(ack);
        ack = !ack;
    endtask
    // Start, address, subaddress, one data byte, stop
    task write(input logic [7:0] sub, input logic [7:0] data, output logic [2:0] acks);
        tick;
        sdaLow = 1'b1;
        tick;
        scl = 1'b0;
        tick;
        send({`PSS_DEV_ADDR, 1'b0}, acks[2]);
        send(sub, acks[1]);
        send(data, acks[0]);
        sdaLow = 1'b1;
        tick;
        scl = 1'b1;
        tick;
        sdaLow = 1'b0;
        tick;
    endtask
endmodule // pss_i2c_master

// [verification/pss_protect_top_tb.sv]
`timescale 1ns/10ps
`include "pss_defs.vh"
module pss_protect_top_tb;
    localparam logic [6:0] RUN = 7'h7c;
    localparam logic [6:0] OFF = 7'h03;
    logic       sys_clk;
    logic       reset_n;
    logic       supplyAbove83;
    logic       supplyAbove81;
    logic       phaseLoopFilterPin;
    logic       guardIn;
    logic       scl;
    logic       sdaLine;
    logic       sdaOe;
    logic       hEn, bEn, vaEn, vbEn, unlockOe, blank, discharge;
    logic [2:0] acks;
    int         errTotal;
    int         checks;
    wire  [6:0] outs = {hEn, bEn, vaEn, vbEn, unlockOe, blank, discharge};

    // ----------------------------------------
    // Block, bus master and clock
    // ----------------------------------------
    pss_protect_top dut
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .supplyAbove83(supplyAbove83),
        .supplyAbove81(supplyAbove81), .overvoltageGuardInput(guardIn),
        .phaseLoopFilterPin(phaseLoopFilterPin), .pllUnlock(1'b0), .scl(scl),
        .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .horizontalDriveOutEn(hEn),
        .bplusDriveOutEn(bEn), .verticalOutAEn(vaEn), .verticalOutBEn(vbEn),
        .syncUnlockFlagOut(), .syncUnlockFlagOe(unlockOe), .clampBlankForce(blank),
        .phaseLoopDischarge(discharge)
    );
    pss_i2c_master mst (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaLine(sdaLine));
    // Free-running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string w, input logic [6:0] s, input logic [6:0] e);
        checks++;
        if (s !== e)
        begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    // Bounded wait for blanking to lift at the end of start-up
    task automatic waitRun(output int n);
        n = 0;
        while (blank !== 1'b0 && n < 8000)
        begin
            step(1);
            n++;
        end
        chk("outputs run", outs, RUN);
    endtask
    task giveVerdict;
        $display("Checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Standby until supply is good and the control register is written
    task tStartup;
        chk("outputs reset", outs, OFF);
        mst.write(`PSS_CTRL_SUB, 8'h01, acks);
        chk("acks low", {4'h0, acks}, 7'h00);
        supplyAbove83 = 1'b1;
        supplyAbove81 = 1'b1;
        step(20);
        mst.write(8'h05, 8'h33, acks);
        chk("acks other", {4'h0, acks}, 7'h06);
        step(1500);
        chk("outputs idle", outs, OFF);
        mst.write(`PSS_CTRL_SUB, 8'h01, acks);
        chk("acks control", {4'h0, acks}, 7'h07);
    endtask
    // Staged start, then a data write is taken while active
    task tSequence;
        int n;
        waitRun(n);
        chk("staged", {6'h0, n > 5000}, 7'h01);
        mst.write(8'h03, 8'h55, acks);
        chk("acks active", {4'h0, acks}, 7'h07);
    endtask
    // Protection only while the loop pin is pulled down
    task tPinProtect;
        int n;
        phaseLoopFilterPin = 1'b0;
        step(10);
        chk("outputs pin", outs, OFF);
        step(2000);
        chk("outputs held", outs, OFF);
        phaseLoopFilterPin = 1'b1;
        waitRun(n);
    endtask
    // Dip in mid-run: restart comes back with supply, outputs wait for a reload
    task tDip;
        int n;
        supplyAbove83 = 1'b0;
        step(5);
        supplyAbove81 = 1'b0;
        step(10);
        chk("outputs dip", outs, OFF);
        supplyAbove83 = 1'b1;
        supplyAbove81 = 1'b1;
        step(2000);
        chk("outputs unloaded", outs, OFF);
        mst.write(8'h03, 8'h11, acks);
        chk("acks reload", {4'h0, acks}, 7'h07);
        waitRun(n);
    endtask
    // Guard trip latches protection until a fresh soft start write
    task tGuard;
        int n;
        guardIn = 1'b1;
        step(10);
        chk("outputs guard", outs, OFF);
        guardIn = 1'b0;
        step(2000);
        chk("outputs latched", outs, OFF);
        mst.write(8'h03, 8'h44, acks);
        chk("acks guard", {4'h0, acks}, 7'h06);
        mst.write(`PSS_CTRL_SUB, 8'h01, acks);
        chk("acks rearm", {4'h0, acks}, 7'h07);
        waitRun(n);
    endtask
    // Low supply clears soft start; slow master brings it back
    task tLowSupply;
        int n;
        mst.quarter = 25;
        supplyAbove83 = 1'b0;
        step(10);
        chk("outputs low", outs, OFF);
        supplyAbove83 = 1'b1;
        step(20);
        mst.write(8'h04, 8'h22, acks);
        chk("acks cleared", {4'h0, acks}, 7'h06);
        mst.write(`PSS_CTRL_SUB, 8'h01, acks);
        chk("acks restart", {4'h0, acks}, 7'h07);
        waitRun(n);
    endtask

    // Hang guard, about twice the expected run length
    initial
    begin
        #1000000;
        errTotal++;
        giveVerdict;
    end
    // Reset for two cycles, then the scenarios in turn
    initial
    begin
        errTotal = 0;
        checks = 0;
        reset_n = 1'b0;
        guardIn = 1'b0;
        supplyAbove83 = 1'b0;
        supplyAbove81 = 1'b0;
        phaseLoopFilterPin = 1'b1;
        step(2);
        reset_n = 1'b1;
        step(2);
        tStartup;
        tSequence;
        tPinProtect;
        tDip;
        tGuard;
        tLowSupply;
        giveVerdict;
    end
endmodule // pss_protect_top_tb
